//--- hdl/insn_exec_unit.sv
// Instruction execution unit with its architectural registers on APB.
module insn_exec_unit
	import exec_unit_pkg::*;
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        sys_rst,
	// APB slave
	input  wire logic [11:0] paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Wake line and state
	input  wire logic        wake_line,
	output logic             halted,
	output logic             busy
);
	localparam state_type ST_RESET = '{fsm: ST_IDLE, cc: FLAGS_RESET, default: '0};

	state_type   st_q;
	state_type   st_d;
	logic [7:0]  mem [256];
	logic        mem_we;
	logic [7:0]  mem_wa;
	logic [7:0]  mem_wd;
	logic [15:0] sp;
	logic [15:0] sp_n;
	logic [15:0] w;
	logic [15:0] off;
	logic [16:0] d17;
	logic [8:0]  sum9;
	logic [4:0]  nib;
	logic [7:0]  acc;
	logic [7:0]  v8;
	logic [7:0]  r8;
	logic [7:0]  va;
	logic [7:0]  fix;
	logic        cin;
	logic        take;
	logic [31:0] rd;
	logic        bad;
	logic [7:0]  p;
	logic [15:0] m;

	function automatic logic [15:0] get_reg(state_type t, logic [3:0] c);
		case (c)
			RC_D:    get_reg = {t.a, t.b};
			RC_X:    get_reg = t.x;
			RC_Y:    get_reg = t.y;
			RC_U:    get_reg = t.u;
			RC_S:    get_reg = t.s;
			RC_PC:   get_reg = t.pc;
			RC_A:    get_reg = {8'h00, t.a};
			RC_B:    get_reg = {8'h00, t.b};
			RC_CC:   get_reg = {8'h00, t.cc};
			RC_DP:   get_reg = {8'h00, t.dp};
			default: get_reg = 16'h0000;
		endcase
	endfunction : get_reg

	function automatic state_type put_reg(state_type t, logic [3:0] c, logic [15:0] v);
		put_reg = t;
		case (c)
			RC_D:    {put_reg.a, put_reg.b} = v;
			RC_X:    put_reg.x = v;
			RC_Y:    put_reg.y = v;
			RC_U:    put_reg.u = v;
			RC_S:    put_reg.s = v;
			RC_PC:   put_reg.pc = v;
			RC_A:    put_reg.a = v[7:0];
			RC_B:    put_reg.b = v[7:0];
			RC_CC:   put_reg.cc = v[7:0];
			RC_DP:   put_reg.dp = v[7:0];
			default: put_reg = t;
		endcase
	endfunction : put_reg

	function automatic logic reg_ok(logic [3:0] c);
		reg_ok = (c <= RC_PC) || (c >= RC_A && c <= RC_DP);
	endfunction : reg_ok

	// Slot order is the stacking order: PC, other pointer, Y, X, DP, B, A, CC.
	function automatic logic [3:0] slot_code(state_type t, logic [3:0] k);
		case (k[3:1])
			3'h0:    slot_code = RC_PC;
			3'h1:    slot_code = t.use_u ? RC_S : RC_U;
			3'h2:    slot_code = RC_Y;
			3'h3:    slot_code = RC_X;
			3'h4:    slot_code = k[0] ? RC_B : RC_DP;
			default: slot_code = k[0] ? RC_CC : RC_A;
		endcase
	endfunction : slot_code

	function automatic logic [2:0] slot_bit(logic [3:0] k);
		slot_bit = k[3] ? 3'(SLOT_LAST - k) : 3'h7 - {1'b0, k[2:1]};
	endfunction : slot_bit

	function automatic logic branch_taken(logic [7:0] f, logic [3:0] c);
		case (c)
			4'h0:    branch_taken = 1'b1;
			4'h1:    branch_taken = 1'b0;
			4'h2:    branch_taken = ~(f[FL_C] | f[FL_Z]);
			4'h3:    branch_taken = f[FL_C] | f[FL_Z];
			4'h4:    branch_taken = ~f[FL_C];
			4'h5:    branch_taken = f[FL_C];
			4'h6:    branch_taken = ~f[FL_Z];
			4'h7:    branch_taken = f[FL_Z];
			4'h8:    branch_taken = ~f[FL_V];
			4'h9:    branch_taken = f[FL_V];
			4'ha:    branch_taken = ~f[FL_N];
			4'hb:    branch_taken = f[FL_N];
			4'hc:    branch_taken = f[FL_N] == f[FL_V];
			4'hd:    branch_taken = f[FL_N] ^ f[FL_V];
			4'he:    branch_taken = ~f[FL_Z] & (f[FL_N] == f[FL_V]);
			default: branch_taken = f[FL_Z] | (f[FL_N] ^ f[FL_V]);
		endcase
	endfunction : branch_taken

	always_comb begin
		st_d = st_q;
		mem_we = 1'b0;
		mem_wa = 8'h00;
		mem_wd = 8'h00;
		p = st_q.post;
		m = st_q.opnd;
		sp = st_q.use_u ? st_q.u : st_q.s;
		sp_n = sp;
		w = 16'h0000;
		off = 16'h0000;
		d17 = 17'h00000;
		sum9 = 9'h000;
		nib = 5'h00;
		acc = p[0] ? st_q.b : st_q.a;
		v8 = 8'h00;
		r8 = 8'h00;
		va = VEC_TRAP3;
		fix = 8'h00;
		cin = p[1] & st_q.cc[FL_C];
		take = 1'b0;
		// The first stage of the wake synchroniser feeds only the second.
		st_d.sync1 = wake_line;
		st_d.sync2 = st_q.sync1;
		unique case (st_q.fsm)
			ST_IDLE: begin
			end
			ST_EXEC: begin
				st_d.fsm = ST_IDLE;
				case (st_q.op)
					OP_NOP: begin
					end
					OP_PRODUCT: begin
						w = 16'(st_q.a) * 16'(st_q.b);
						{st_d.a, st_d.b} = w;
						st_d.cc[FL_Z] = w == 16'h0000;
						st_d.cc[FL_C] = w[7];
					end
					OP_SIGN_WIDEN: begin
						st_d.a = {8{st_q.b[7]}};
						st_d.cc[FL_N] = st_q.b[7];
						st_d.cc[FL_Z] = st_q.b == 8'h00;
					end
					OP_ADD_INDEX: st_d.x = st_q.x + {8'h00, st_q.b};
					OP_BCD_ADJUST: begin
						if (st_q.cc[FL_H] || st_q.a[3:0] > 4'h9) fix[3:0] = 4'h6;
						if (st_q.cc[FL_C] || st_q.a[7:4] > 4'h9
							|| (st_q.a[7:4] > 4'h8 && st_q.a[3:0] > 4'h9)) fix[7:4] = 4'h6;
						sum9 = {1'b0, st_q.a} + {1'b0, fix};
						st_d.a = sum9[7:0];
						st_d.cc[FL_N] = sum9[7];
						st_d.cc[FL_Z] = sum9[7:0] == 8'h00;
						st_d.cc[FL_C] = st_q.cc[FL_C] | sum9[8];
					end
					OP_MASK_WAIT, OP_TRAP1, OP_TRAP2, OP_TRAP3: begin
						// All registers except S are stacked on S before waiting or vectoring.
						if (st_q.op == OP_MASK_WAIT) st_d.cc = st_q.cc & m[7:0];
						st_d.cc[FL_E] = 1'b1;
						st_d.post = SAVE_ALL;
						st_d.use_u = 1'b0;
						st_d.slot = 4'h0;
						st_d.fsm = ST_PUSH;
					end
					OP_SWAP: begin
						if (reg_ok(p[7:4]) && reg_ok(p[3:0]) && p[7] == p[3]) begin
							st_d = put_reg(st_d, p[3:0], get_reg(st_q, p[7:4]));
							st_d = put_reg(st_d, p[7:4], get_reg(st_q, p[3:0]));
						end else st_d.err = 1'b1;
					end
					OP_COPY: begin
						if (reg_ok(p[7:4]) && reg_ok(p[3:0]) && p[7] == p[3])
							st_d = put_reg(st_d, p[3:0], get_reg(st_q, p[7:4]));
						else st_d.err = 1'b1;
					end
					OP_HW_SAVE, OP_USER_SAVE: begin
						st_d.use_u = st_q.op == OP_USER_SAVE;
						st_d.slot = 4'h0;
						st_d.fsm = ST_PUSH;
					end
					OP_HW_REST, OP_USER_REST: begin
						st_d.use_u = st_q.op == OP_USER_REST;
						st_d.slot = SLOT_LAST;
						st_d.fsm = ST_PULL;
					end
					OP_EA_LOAD: begin
						w = get_reg(st_q, 4'(p[3:2]) + RC_X) + m;
						st_d = put_reg(st_d, 4'(p[1:0]) + RC_X, w);
						if (!p[1]) st_d.cc[FL_Z] = w == 16'h0000;
					end
					OP_ADD8, OP_SUB8: begin
						nib = {1'b0, acc[3:0]} + {1'b0, m[3:0]} + {4'h0, cin};
						if (st_q.op == OP_ADD8) begin
							sum9 = {1'b0, acc} + {1'b0, m[7:0]} + {8'h00, cin};
							st_d.cc[FL_H] = nib[4];
							st_d.cc[FL_V] = (acc[7] == m[7]) && (sum9[7] != acc[7]);
						end else begin
							sum9 = {1'b0, acc} - {1'b0, m[7:0]} - {8'h00, cin};
							st_d.cc[FL_V] = (acc[7] != m[7]) && (sum9[7] != acc[7]);
						end
						st_d.cc[FL_N] = sum9[7];
						st_d.cc[FL_Z] = sum9[7:0] == 8'h00;
						st_d.cc[FL_C] = sum9[8];
						if (p[0]) st_d.b = sum9[7:0];
						else st_d.a = sum9[7:0];
					end
					OP_UNARY: begin
						v8 = p[5:4] == 2'h0 ? st_q.a : (p[5:4] == 2'h1 ? st_q.b : m[7:0]);
						st_d.cc[FL_V] = 1'b0;
						case (p[2:0])
							3'h0: begin
								r8 = 8'h00 - v8;
								st_d.cc[FL_V] = v8 == 8'h80;
								st_d.cc[FL_C] = v8 != 8'h00;
							end
							3'h1: begin
								r8 = ~v8;
								st_d.cc[FL_C] = 1'b1;
							end
							3'h2: st_d.cc[FL_C] = 1'b0;
							3'h3: begin
								r8 = v8 + 8'h01;
								st_d.cc[FL_V] = v8 == 8'h7f;
							end
							3'h4: begin
								r8 = v8 - 8'h01;
								st_d.cc[FL_V] = v8 == 8'h80;
							end
							default: r8 = v8;
						endcase
						st_d.cc[FL_N] = r8[7];
						st_d.cc[FL_Z] = r8 == 8'h00;
						if (p[2:0] <= 3'h4) begin
							if (p[5:4] == 2'h0) st_d.a = r8;
							else if (p[5:4] == 2'h1) st_d.b = r8;
							else st_d.opnd[7:0] = r8;
						end
					end
					OP_COMPARE16: begin
						w = get_reg(st_q, {1'b0, p[2:0]});
						d17 = {1'b0, w} - {1'b0, m};
						st_d.cc[FL_N] = d17[15];
						st_d.cc[FL_Z] = d17[15:0] == 16'h0000;
						st_d.cc[FL_V] = (w[15] != m[15]) && (d17[15] != w[15]);
						st_d.cc[FL_C] = d17[16];
					end
					OP_FLAGS_AND: st_d.cc = st_q.cc & m[7:0];
					OP_FLAGS_OR:  st_d.cc = st_q.cc | m[7:0];
					OP_BR_SHORT, OP_BR_LONG: begin
						off = st_q.op == OP_BR_LONG ? m : {{8{m[7]}}, m[7:0]};
						take = branch_taken(st_q.cc, p[3:0]);
						if (take) st_d.pc = st_q.pc + off;
					end
					OP_SYNC: st_d.fsm = ST_WAIT;
					default: st_d.err = 1'b1;
				endcase
			end
			ST_PUSH: begin
				if (p[slot_bit(st_q.slot)]) begin
					sp_n = sp - 16'h0001;
					w = get_reg(st_q, slot_code(st_q, st_q.slot));
					mem_we = 1'b1;
					mem_wa = sp_n[7:0];
					mem_wd = st_q.slot[3] || !st_q.slot[0] ? w[7:0] : w[15:8];
				end
				st_d.slot = st_q.slot + 4'h1;
				if (st_q.slot == SLOT_LAST) begin
					if (st_q.op == OP_MASK_WAIT) st_d.fsm = ST_WAIT;
					else if (st_q.op >= OP_TRAP1 && st_q.op <= OP_TRAP3) st_d.fsm = ST_VECT;
					else st_d.fsm = ST_IDLE;
				end
			end
			ST_PULL: begin
				if (p[slot_bit(st_q.slot)]) begin
					sp_n = sp + 16'h0001;
					w = get_reg(st_q, slot_code(st_q, st_q.slot));
					if (st_q.slot[3] || !st_q.slot[0]) w[7:0] = mem[sp[7:0]];
					else w[15:8] = mem[sp[7:0]];
					st_d = put_reg(st_d, slot_code(st_q, st_q.slot), w);
				end
				st_d.slot = st_q.slot - 4'h1;
				if (st_q.slot == 4'h0) st_d.fsm = ST_IDLE;
			end
			ST_VECT: begin
				if (st_q.op == OP_TRAP1) va = VEC_TRAP1;
				else if (st_q.op == OP_TRAP2) va = VEC_TRAP2;
				st_d.pc = {mem[va], mem[va + 8'h01]};
				if (st_q.op == OP_TRAP1) st_d.cc = st_q.cc | 8'h50;
				st_d.fsm = ST_IDLE;
			end
			ST_WAIT: if (st_q.sync2) st_d.fsm = ST_IDLE;
		endcase
		if (st_q.fsm == ST_PUSH || st_q.fsm == ST_PULL) begin
			if (st_q.use_u) st_d.u = sp_n;
			else st_d.s = sp_n;
		end
		// APB: decode in setup, answer in the first access cycle.
		rd = 32'h00000000;
		bad = 1'b0;
		if (paddr[11:10] == MEM_WINDOW) rd = {24'h000000, mem[paddr[9:2]]};
		else begin
			case (paddr)
				ADDR_ACC_A, ADDR_ACC_B, ADDR_FLAGS, ADDR_PAGE,
				ADDR_INDEX_X, ADDR_INDEX_Y, ADDR_STACK_U, ADDR_STACK_S, ADDR_PROG_CTR:
					// Low four words hold the byte registers, the next five the pointers.
					rd = {16'h0000, get_reg(st_q, paddr[5] | paddr[4]
						? paddr[5:2] - 4'h3 : paddr[5:2] | 4'h8)};
				ADDR_OPERAND: rd = {16'h0000, st_q.opnd};
				ADDR_COMMAND: rd = {16'h0000, st_q.post, 3'h0, st_q.op};
				ADDR_STATUS:  rd = {29'h00000000, st_q.err, st_q.halt, st_q.busy};
				default:      bad = 1'b1;
			endcase
		end
		st_d.ready = psel & ~penable;
		st_d.rdata = psel & ~penable ? rd : 32'h00000000;
		// Writes are refused while an instruction runs, so state never tears.
		st_d.slverr = psel & ~penable & (bad | (pwrite & st_q.busy));
		if (psel && penable && st_q.ready && !st_q.slverr && pwrite) begin
			if (paddr[11:10] == MEM_WINDOW) begin
				mem_we = 1'b1;
				mem_wa = paddr[9:2];
				mem_wd = pwdata[7:0];
			end else begin
				case (paddr)
					ADDR_ACC_A:    st_d.a = pwdata[7:0];
					ADDR_ACC_B:    st_d.b = pwdata[7:0];
					ADDR_FLAGS:    st_d.cc = pwdata[7:0];
					ADDR_PAGE:     st_d.dp = pwdata[7:0];
					ADDR_INDEX_X:  st_d.x = pwdata[15:0];
					ADDR_INDEX_Y:  st_d.y = pwdata[15:0];
					ADDR_STACK_U:  st_d.u = pwdata[15:0];
					ADDR_STACK_S:  st_d.s = pwdata[15:0];
					ADDR_PROG_CTR: st_d.pc = pwdata[15:0];
					ADDR_OPERAND:  st_d.opnd = pwdata[15:0];
					ADDR_COMMAND: begin
						st_d.op = pwdata[4:0];
						st_d.post = pwdata[15:8];
						st_d.fsm = ST_EXEC;
					end
					default: if (pwdata[STAT_ERR]) st_d.err = 1'b0;
				endcase
			end
		end
		st_d.busy = st_d.fsm != ST_IDLE;
		st_d.halt = st_d.fsm == ST_WAIT;
	end

	always_ff @(posedge clk) begin
		if (sys_rst) st_q <= ST_RESET;
		else st_q <= st_d;
	end

	// Stack memory sees only the low address byte; pointers wrap within it.
	always_ff @(posedge clk) begin
		if (mem_we) mem[mem_wa] <= mem_wd;
	end

	assign prdata  = st_q.rdata;
	assign pready  = st_q.ready;
	assign pslverr = st_q.slverr;
	assign halted  = st_q.halt;
	assign busy    = st_q.busy;

	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);

	logic ex;
	assign ex = st_q.fsm == ST_EXEC;

	sequence seq_push_all;
		(st_q.fsm == ST_PUSH)[*8] ##1 (st_q.fsm == ST_PUSH)[*4];
	endsequence

	chk_product_result: assert property (ex && st_q.op == OP_PRODUCT |=>
		{st_q.a, st_q.b} == 16'($past(st_q.a)) * 16'($past(st_q.b)))
		else $error("product result wrong");
	chk_sign_widen_fill: assert property (ex && st_q.op == OP_SIGN_WIDEN |=>
		st_q.a == {8{$past(st_q.b[7])}} && $stable(st_q.b))
		else $error("sign widen wrong");
	chk_index_add: assert property (ex && st_q.op == OP_ADD_INDEX |=>
		st_q.x == $past(st_q.x) + {8'h00, $past(st_q.b)})
		else $error("index add wrong");
	chk_wait_entry: assert property (ex && st_q.op == OP_MASK_WAIT |=>
		(st_q.cc[FL_E] and seq_push_all) ##1 halted)
		else $error("mask then wait did not halt");
	chk_flags_or: assert property (ex && st_q.op == OP_FLAGS_OR |=>
		st_q.cc == ($past(st_q.cc) | $past(st_q.opnd[7:0])))
		else $error("flag or wrong");
	chk_higher_same: assert property (ex && st_q.op == OP_BR_SHORT && p[3:0] == 4'h4 |=>
		st_q.pc == ($past(st_q.cc[FL_C]) ? $past(st_q.pc)
		: $past(st_q.pc) + {{8{$past(st_q.opnd[7])}}, $past(st_q.opnd[7:0])}))
		else $error("higher or same branch wrong");
	chk_signed_ge: assert property (ex && st_q.op == OP_BR_LONG && p[3:0] == 4'hc |=>
		st_q.pc == ($past(st_q.cc[FL_N] == st_q.cc[FL_V]) ? $past(st_q.pc + st_q.opnd)
		: $past(st_q.pc)))
		else $error("signed ge branch wrong");
	chk_trap_vector: assert property (ex && st_q.op == OP_TRAP1 |=>
		seq_push_all ##1 st_q.fsm == ST_VECT ##1 (st_q.cc[FL_I] && st_q.cc[FL_F] && !busy))
		else $error("trap sequence wrong");
	chk_add_half: assert property (ex && st_q.op == OP_ADD8 && !p[0] |=>
		st_q.cc[FL_H] == (({1'b0, $past(st_q.a[3:0])} + {1'b0, $past(st_q.opnd[3:0])}
		+ {4'h0, $past(cin)}) > 5'h0f))
		else $error("half carry wrong");
	chk_sync_halt: assert property (ex && st_q.op == OP_SYNC |=> halted)
		else $error("sync did not halt");
endmodule : insn_exec_unit

//--- hdl/exec_unit_pkg.sv
// Constants and types shared by the instruction execution unit.
package exec_unit_pkg;
	// Register word addresses on the APB.
	localparam logic [11:0] ADDR_ACC_A    = 12'h000;
	localparam logic [11:0] ADDR_ACC_B    = 12'h004;
	localparam logic [11:0] ADDR_FLAGS    = 12'h008;
	localparam logic [11:0] ADDR_PAGE     = 12'h00c;
	localparam logic [11:0] ADDR_INDEX_X  = 12'h010;
	localparam logic [11:0] ADDR_INDEX_Y  = 12'h014;
	localparam logic [11:0] ADDR_STACK_U  = 12'h018;
	localparam logic [11:0] ADDR_STACK_S  = 12'h01c;
	localparam logic [11:0] ADDR_PROG_CTR = 12'h020;
	localparam logic [11:0] ADDR_OPERAND  = 12'h024;
	localparam logic [11:0] ADDR_COMMAND  = 12'h028;
	localparam logic [11:0] ADDR_STATUS   = 12'h02c;
	localparam logic [1:0]  MEM_WINDOW    = 2'h1;
	// Status bits.
	localparam int STAT_BUSY = 0;
	localparam int STAT_HALT = 1;
	localparam int STAT_ERR  = 2;
	// Values after reset.
	localparam logic [7:0]  FLAGS_RESET = 8'h50;
	localparam logic [15:0] WORD_RESET  = 16'h0000;
	// Command codes.
	localparam logic [4:0] OP_NOP        = 5'h00;
	localparam logic [4:0] OP_PRODUCT    = 5'h01;
	localparam logic [4:0] OP_SIGN_WIDEN = 5'h02;
	localparam logic [4:0] OP_ADD_INDEX  = 5'h03;
	localparam logic [4:0] OP_BCD_ADJUST = 5'h04;
	localparam logic [4:0] OP_MASK_WAIT  = 5'h05;
	localparam logic [4:0] OP_SWAP       = 5'h06;
	localparam logic [4:0] OP_COPY       = 5'h07;
	localparam logic [4:0] OP_HW_SAVE    = 5'h08;
	localparam logic [4:0] OP_USER_SAVE  = 5'h09;
	localparam logic [4:0] OP_HW_REST    = 5'h0a;
	localparam logic [4:0] OP_USER_REST  = 5'h0b;
	localparam logic [4:0] OP_EA_LOAD    = 5'h0c;
	localparam logic [4:0] OP_ADD8       = 5'h0d;
	localparam logic [4:0] OP_SUB8       = 5'h0e;
	localparam logic [4:0] OP_UNARY      = 5'h0f;
	localparam logic [4:0] OP_COMPARE16  = 5'h10;
	localparam logic [4:0] OP_FLAGS_AND  = 5'h11;
	localparam logic [4:0] OP_FLAGS_OR   = 5'h12;
	localparam logic [4:0] OP_BR_SHORT   = 5'h13;
	localparam logic [4:0] OP_BR_LONG    = 5'h14;
	localparam logic [4:0] OP_TRAP1      = 5'h15;
	localparam logic [4:0] OP_TRAP2      = 5'h16;
	localparam logic [4:0] OP_TRAP3      = 5'h17;
	localparam logic [4:0] OP_SYNC       = 5'h18;
	// Register select codes for swap, copy and compare.
	localparam logic [3:0] RC_D  = 4'h0;
	localparam logic [3:0] RC_X  = 4'h1;
	localparam logic [3:0] RC_Y  = 4'h2;
	localparam logic [3:0] RC_U  = 4'h3;
	localparam logic [3:0] RC_S  = 4'h4;
	localparam logic [3:0] RC_PC = 4'h5;
	localparam logic [3:0] RC_A  = 4'h8;
	localparam logic [3:0] RC_B  = 4'h9;
	localparam logic [3:0] RC_CC = 4'ha;
	localparam logic [3:0] RC_DP = 4'hb;
	// Flag bit positions.
	localparam int FL_E = 7;
	localparam int FL_F = 6;
	localparam int FL_H = 5;
	localparam int FL_I = 4;
	localparam int FL_N = 3;
	localparam int FL_Z = 2;
	localparam int FL_V = 1;
	localparam int FL_C = 0;
	// Trap vectors and stacking.
	localparam logic [7:0] VEC_TRAP1 = 8'hfa;
	localparam logic [7:0] VEC_TRAP2 = 8'hf4;
	localparam logic [7:0] VEC_TRAP3 = 8'hf2;
	localparam logic [7:0] SAVE_ALL  = 8'hff;
	localparam logic [3:0] SLOT_LAST = 4'hb;

	typedef enum logic [5:0] {
		ST_IDLE = 6'h01,
		ST_EXEC = 6'h02,
		ST_PUSH = 6'h04,
		ST_PULL = 6'h08,
		ST_VECT = 6'h10,
		ST_WAIT = 6'h20
	} fsm_type;

	typedef struct packed {
		fsm_type     fsm;
		logic [7:0]  a;
		logic [7:0]  b;
		logic [7:0]  cc;
		logic [7:0]  dp;
		logic [15:0] x;
		logic [15:0] y;
		logic [15:0] u;
		logic [15:0] s;
		logic [15:0] pc;
		logic [15:0] opnd;
		logic [7:0]  post;
		logic [4:0]  op;
		logic [3:0]  slot;
		logic        use_u;
		logic        err;
		logic        busy;
		logic        halt;
		logic        sync1;
		logic        sync2;
		logic [31:0] rdata;
		logic        ready;
		logic        slverr;
	} state_type;
endpackage : exec_unit_pkg

//--- verification/wake_source.sv
// External event source that drives the wake line of the execution unit.
module wake_source (
	// Clock and request from the bench
	input  wire logic clk,
	input  wire logic fire,
	// Wake line
	output logic      wake_line
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] cnt_q = 4'h0;
	// Held for eight cycles so the two-flop synchroniser cannot miss it.
	always_ff @(posedge clk) begin
		cnt_q <= fire ? 4'h8 : cnt_q - {3'h0, cnt_q != 4'h0};
	end
	assign wake_line = cnt_q != 4'h0;
endmodule : wake_source

//--- verification/tb_top.sv
// Self-checking bench for the instruction execution unit.
module tb_top
	import exec_unit_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct packed {
		logic [4:0]  op;
		logic [7:0]  po, a, b, f;
		logic [15:0] x, d;
		logic [7:0]  ea, eb;
		logic [15:0] ex;
		logic [7:0]  ef, fm;
	} row_type;
	logic        clk = 1'b0;
	logic        sys_rst = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic        fire = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rd;
	logic        pready, pslverr, serr, wake_line, halted, busy;
	logic [7:0]  v;
	logic [7:0]  fl [6] = '{8'h00, 8'h0f, 8'h0a, 8'h05, 8'h08, 8'h02};
	row_type     r;
	int          err_total = 0;
	int          tests_run = 0;
	int          cyc = 0;
	row_type     rows [16] = '{
		'{OP_PRODUCT, 8'h00, 8'hff, 8'hff, 8'h00, 16'h0, 16'h0, 8'hfe, 8'h01, 16'h0, 8'h0, 8'h0},
		'{OP_SIGN_WIDEN, 8'h00, 8'h00, 8'h80, 8'h00, 16'h0, 16'h0, 8'hff, 8'h80, 16'h0, 8'h0,
			8'h0},
		'{OP_ADD_INDEX, 8'h00, 8'h00, 8'hff, 8'h00, 16'h00ff, 16'h0, 8'h00, 8'hff, 16'h01fe,
			8'h0, 8'h0},
		'{OP_BCD_ADJUST, 8'h00, 8'h9a, 8'h00, 8'h00, 16'h0, 16'h0, 8'h00, 8'h00, 16'h0, 8'h01,
			8'h01},
		'{OP_ADD8, 8'h02, 8'h01, 8'h00, 8'h01, 16'h0, 16'h000f, 8'h11, 8'h00, 16'h0, 8'h20, 8'h21},
		'{OP_SUB8, 8'h03, 8'h00, 8'h10, 8'h01, 16'h0, 16'h0001, 8'h00, 8'h0e, 16'h0, 8'h00, 8'h01},
		'{OP_UNARY, 8'h00, 8'h01, 8'h00, 8'h00, 16'h0, 16'h0, 8'hff, 8'h00, 16'h0, 8'h08, 8'h08},
		'{OP_UNARY, 8'h11, 8'h00, 8'h0f, 8'h00, 16'h0, 16'h0, 8'h00, 8'hf0, 16'h0, 8'h00, 8'h00},
		'{OP_UNARY, 8'h03, 8'h7f, 8'h00, 8'h00, 16'h0, 16'h0, 8'h80, 8'h00, 16'h0, 8'h0a, 8'h0a},
		'{OP_UNARY, 8'h14, 8'h00, 8'h01, 8'h00, 16'h0, 16'h0, 8'h00, 8'h00, 16'h0, 8'h04, 8'h06},
		'{OP_SWAP, 8'h89, 8'h01, 8'h02, 8'h00, 16'h0, 16'h0, 8'h02, 8'h01, 16'h0, 8'h00, 8'h00},
		'{OP_COPY, 8'h89, 8'h01, 8'h02, 8'h00, 16'h0, 16'h0, 8'h01, 8'h01, 16'h0, 8'h00, 8'h00},
		'{OP_SWAP, 8'h01, 8'h12, 8'h34, 8'h00, 16'h5678, 16'h0, 8'h56, 8'h78, 16'h1234, 8'h0,
			8'h0},
		'{OP_COPY, 8'h10, 8'h00, 8'h00, 8'h00, 16'habcd, 16'h0, 8'hab, 8'hcd, 16'habcd, 8'h0,
			8'h0},
		'{OP_EA_LOAD, 8'h00, 8'h00, 8'h00, 8'h00, 16'h0100, 16'hfff0, 8'h00, 8'h00, 16'h00f0,
			8'h0, 8'h0},
		'{OP_COMPARE16, 8'h00, 8'h12, 8'h34, 8'h00, 16'h0, 16'h1234, 8'h12, 8'h34, 16'h0, 8'h04,
			8'h04}};

	insn_exec_unit i_dut (.clk(clk), .sys_rst(sys_rst), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .wake_line(wake_line), .halted(halted), .busy(busy));
	wake_source i_wake (.clk(clk), .fire(fire), .wake_line(wake_line));

	always #10 clk = ~clk;

	// Ceiling set well above the few thousand cycles the sequence needs.
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			results();
		end
	end

	task automatic results;
		$display("checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : results

	task automatic cmp(input logic ok, input string what);
		tests_run++;
		if (ok !== 1'b1) begin
			err_total++;
			$display("FAIL %0t %s", $time, what);
		end
	endtask : cmp

	task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] wd);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= ad;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		serr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic chk(input logic [11:0] ad, input logic [15:0] ex, input logic [15:0] m);
		apb(1'b0, ad, 32'h0);
		cmp((rd[15:0] & m) === (ex & m), $sformatf("addr %h read %h want %h", ad, rd[15:0], ex));
	endtask : chk

	task automatic run(input logic [4:0] op, input logic [7:0] po);
		apb(1'b1, ADDR_COMMAND, {16'h0, po, 3'h0, op});
		@(posedge clk);
		while (busy === 1'b1 && halted !== 1'b1) begin
			@(posedge clk);
		end
	endtask : run

	task automatic hold_wake;
		repeat (8) @(posedge clk);
		cmp(halted === 1'b1, "not halted");
		fire <= 1'b1;
		@(posedge clk);
		fire <= 1'b0;
		repeat (8) @(posedge clk);
		cmp(halted === 1'b0, "still halted");
	endtask : hold_wake

	function automatic logic tk(input int c, input logic [7:0] f);
		logic n, z, o, k;
		n = f[FL_N];
		z = f[FL_Z];
		o = f[FL_V];
		k = f[FL_C];
		case (c)
			0: return 1'b1;
			1: return 1'b0;
			2: return !(k | z);
			3: return k | z;
			4: return !k;
			5: return k;
			6: return !z;
			7: return z;
			8: return !o;
			9: return o;
			10: return !n;
			11: return n;
			12: return n == o;
			13: return n != o;
			14: return !z && n == o;
			default: return z || n != o;
		endcase
	endfunction : tk

	initial begin
		repeat (20) @(posedge clk);
		sys_rst <= 1'b0;
		chk(ADDR_FLAGS, 16'h0050, 16'h00ff);
		apb(1'b0, 12'h300, 32'h0);
		cmp(serr === 1'b1 && rd === 32'h0, "unmapped read");
		$display("reset and map done");
		foreach (rows[i]) begin
			r = rows[i];
			apb(1'b1, ADDR_ACC_A, {24'h0, r.a});
			apb(1'b1, ADDR_ACC_B, {24'h0, r.b});
			apb(1'b1, ADDR_FLAGS, {24'h0, r.f});
			apb(1'b1, ADDR_INDEX_X, {16'h0, r.x});
			apb(1'b1, ADDR_OPERAND, {16'h0, r.d});
			run(r.op, r.po);
			chk(ADDR_ACC_A, {8'h0, r.ea}, 16'h00ff);
			chk(ADDR_ACC_B, {8'h0, r.eb}, 16'h00ff);
			chk(ADDR_INDEX_X, r.ex, {16{r.op != OP_COMPARE16}});
			chk(ADDR_FLAGS, {8'h0, r.ef}, {8'h0, r.fm});
			$display("row %0d done", i);
		end
		apb(1'b1, ADDR_FLAGS, 32'h0);
		apb(1'b1, ADDR_OPERAND, 32'h0f);
		run(OP_FLAGS_OR, 8'h00);
		chk(ADDR_FLAGS, 16'h000f, 16'h00ff);
		apb(1'b1, ADDR_OPERAND, 32'hf5);
		run(OP_FLAGS_AND, 8'h00);
		chk(ADDR_FLAGS, 16'h0005, 16'h00ff);
		foreach (fl[i]) for (int c = 0; c < 16; c++) begin
			apb(1'b1, ADDR_FLAGS, {24'h0, fl[i]});
			apb(1'b1, ADDR_PROG_CTR, 32'h1000);
			apb(1'b1, ADDR_OPERAND, 32'h00f0);
			run(OP_BR_SHORT, 8'(c));
			chk(ADDR_PROG_CTR, tk(c, fl[i]) ? 16'h0ff0 : 16'h1000, 16'hffff);
		end
		apb(1'b1, ADDR_PROG_CTR, 32'h1000);
		run(OP_BR_LONG, 8'h00);
		chk(ADDR_PROG_CTR, 16'h10f0, 16'hffff);
		run(OP_BR_LONG, 8'h01);
		chk(ADDR_PROG_CTR, 16'h10f0, 16'hffff);
		run(OP_BR_LONG, 8'h0c);
		chk(ADDR_PROG_CTR, 16'h10f0, 16'hffff);
		apb(1'b1, ADDR_FLAGS, 32'h0a);
		run(OP_BR_LONG, 8'h0c);
		chk(ADDR_PROG_CTR, 16'h11e0, 16'hffff);
		$display("branches done");
		apb(1'b1, ADDR_ACC_A, 32'h11);
		apb(1'b1, ADDR_INDEX_X, 32'h3344);
		apb(1'b1, ADDR_STACK_S, 32'h80);
		apb(1'b1, ADDR_PROG_CTR, 32'h5566);
		run(OP_HW_SAVE, SAVE_ALL);
		chk(ADDR_STACK_S, 16'h0074, 16'hffff);
		chk(12'h5d4, 16'h0011, 16'h00ff);
		chk(12'h5fc, 16'h0066, 16'h00ff);
		apb(1'b1, ADDR_ACC_A, 32'h0);
		apb(1'b1, ADDR_INDEX_X, 32'h0);
		run(OP_HW_REST, SAVE_ALL);
		chk(ADDR_ACC_A, 16'h0011, 16'h00ff);
		chk(ADDR_INDEX_X, 16'h3344, 16'hffff);
		chk(ADDR_STACK_S, 16'h0080, 16'hffff);
		apb(1'b1, ADDR_STACK_U, 32'h40);
		apb(1'b1, ADDR_ACC_B, 32'h22);
		run(OP_USER_SAVE, 8'h04);
		chk(ADDR_STACK_U, 16'h003f, 16'hffff);
		chk(12'h4fc, 16'h0022, 16'h00ff);
		apb(1'b1, ADDR_ACC_B, 32'h0);
		run(OP_USER_REST, 8'h04);
		chk(ADDR_ACC_B, 16'h0022, 16'h00ff);
		chk(ADDR_STACK_U, 16'h0040, 16'hffff);
		run(OP_SWAP, 8'h08);
		chk(ADDR_STATUS, 16'h0004, 16'h0007);
		apb(1'b1, ADDR_STATUS, 32'h4);
		chk(ADDR_STATUS, 16'h0000, 16'h0007);
		$display("stack done");
		for (int t = 0; t < 3; t++) begin
			v = t == 0 ? VEC_TRAP1 : t == 1 ? VEC_TRAP2 : VEC_TRAP3;
			apb(1'b1, 12'h400 + {2'h0, v, 2'h0}, 32'h12);
			apb(1'b1, 12'h404 + {2'h0, v, 2'h0}, 32'h30 + t);
			apb(1'b1, ADDR_STACK_S, 32'h80);
			run(OP_TRAP1 + 5'(t), 8'h00);
			chk(ADDR_PROG_CTR, 16'h1230 + 16'(t), 16'hffff);
		end
		$display("traps done");
		apb(1'b1, ADDR_FLAGS, 32'hff);
		apb(1'b1, ADDR_OPERAND, 32'hef);
		run(OP_MASK_WAIT, 8'h00);
		hold_wake();
		chk(ADDR_FLAGS, 16'h006f, 16'h007f);
		run(OP_SYNC, 8'h00);
		hold_wake();
		$display("wait done");
		sys_rst <= 1'b1;
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		chk(ADDR_ACC_A, 16'h0000, 16'h00ff);
		chk(ADDR_FLAGS, 16'h0050, 16'h00ff);
		$display("second reset done");
		results();
	end
endmodule : tb_top
